// ==== common/rx_walk_consts.vh ====
`ifndef RX_WALK_CONSTS_VH
`define RX_WALK_CONSTS_VH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define REG_CTRL        8'h00
`define REG_LIST_BASE   8'h04
`define REG_CUR_DESC    8'h08
`define REG_STATUS      8'h0c
`define REG_FRAME_CNT   8'h10
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET_VAL  32'h0000_0000
`define BASE_RESET_VAL  32'h0000_0000
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
// ----------------------------------------
// receive descriptor layout
// ----------------------------------------
`define DESC_CTRL_OFS   32'h0000_0004
`define DESC_PTR1_OFS   32'h0000_0008
`define DESC_PTR2_OFS   32'h0000_000c
`define DESC_STRIDE     32'h0000_0010
`define CW_RING_END     15
`define CW_CHAINED      14
`define CW_SIZE1_MSB    12
`define CW_SIZE1_LSB    0
`define CW_SIZE2_MSB    28
`define CW_SIZE2_LSB    16
`define SIZE_W          13
`define FIFO_DEPTH      16
`endif

// ==== hdl/rx_byte_fifo.v ====
`timescale 1ns/1ns
`default_nettype none
module rx_byte_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             i_sys_clk,
	input  wire             i_nrst,
	input  wire             i_in_valid,
	input  wire [WIDTH-1:0] i_in_data,
	output wire             o_in_ready,
	output wire             o_out_valid,
	output wire [WIDTH-1:0] o_out_data,
	input  wire             i_out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	// honest full and empty from the fill count
	assign o_in_ready  = (count != DEPTH[AW:0]);
	assign o_out_valid = (count != {(AW+1){1'b0}});
	assign o_out_data  = mem[rd_ptr];
	assign push = i_in_valid && o_in_ready;
	assign pop  = o_out_valid && i_out_ready;

	// storage, no reset needed on the array
	always @(posedge i_sys_clk) begin
		if (push)
			mem[wr_ptr] <= i_in_data;
	end

	// pointers wrap at depth
	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/rx_desc_decode.v ====
`timescale 1ns/1ns
`default_nettype none
`include "rx_walk_consts.vh"
module rx_desc_decode (
	input  wire [31:0]         i_control_word,
	input  wire [31:0]         i_second_pointer,
	output wire                o_ring_end,
	output wire                o_chained,
	output wire [`SIZE_W-1:0]  o_first_size,
	output wire [`SIZE_W-1:0]  o_second_size,
	output wire [31:0]         o_next_desc
);
	// control word fields
	assign o_ring_end   = i_control_word[`CW_RING_END];
	assign o_chained    = i_control_word[`CW_CHAINED];
	assign o_first_size = i_control_word[`CW_SIZE1_MSB:`CW_SIZE1_LSB];
	// second size is a don't care while chained
	assign o_second_size = o_chained ? {`SIZE_W{1'b0}} :
		i_control_word[`CW_SIZE2_MSB:`CW_SIZE2_LSB];
	// chained pointer low bits ignored
	assign o_next_desc = {i_second_pointer[31:2], 2'b00};
endmodule
`default_nettype wire

// ==== hdl/rx_desc_walker.v ====
`timescale 1ns/1ns
`default_nettype none
`include "rx_walk_consts.vh"
module rx_desc_walker #(
	parameter ADDR_W     = 8,
	parameter FIFO_DEPTH = `FIFO_DEPTH,
	parameter FIFO_AW    = 4
) (
	input  wire              i_sys_clk,
	input  wire              i_nrst,
	// axi4-lite register port
	input  wire [ADDR_W-1:0] i_s_awaddr,
	input  wire              i_s_awvalid,
	output wire              o_s_awready,
	input  wire [31:0]       i_s_wdata,
	input  wire [3:0]        i_s_wstrb,
	input  wire              i_s_wvalid,
	output wire              o_s_wready,
	output reg  [1:0]        o_s_bresp,
	output reg               o_s_bvalid,
	input  wire              i_s_bready,
	input  wire [ADDR_W-1:0] i_s_araddr,
	input  wire              i_s_arvalid,
	output wire              o_s_arready,
	output reg  [31:0]       o_s_rdata,
	output reg  [1:0]        o_s_rresp,
	output reg               o_s_rvalid,
	input  wire              i_s_rready,
	// received byte stream
	input  wire              i_rx_valid,
	input  wire [7:0]        i_rx_data,
	input  wire              i_rx_last,
	output wire              o_rx_ready,
	// system memory port
	output reg               o_mem_req,
	output reg               o_mem_we,
	output reg  [31:0]       o_mem_addr,
	output reg  [31:0]       o_mem_wdata,
	output reg  [3:0]        o_mem_strb,
	input  wire              i_mem_ack,
	input  wire [31:0]       i_mem_rdata
);
	// ----------------------------------------
	// states and helpers
	// ----------------------------------------
	localparam ST_IDLE    = 3'd0;
	localparam ST_FETCH   = 3'd1;
	localparam ST_PICK1   = 3'd2;
	localparam ST_PICK2   = 3'd3;
	localparam ST_FILL    = 3'd4;
	localparam ST_ADVANCE = 3'd5;
	// reset image of the control register, enable taken from its bit
	localparam [31:0] CTRL_RST = `CTRL_RESET_VAL;

	// clear the two low address bits
	function [31:0] word_align;
		input [31:0] addr;
		begin
			word_align = {addr[31:2], 2'b00};
		end
	endfunction

	// one-hot byte lane of an address
	function [3:0] lane_strb;
		input [1:0] lane;
		begin
			lane_strb = 4'h1 << lane;
		end
	endfunction

	reg  [2:0]           state;
	reg  [1:0]           fetch_idx;
	reg  [31:0]          control_word;
	reg  [31:0]          first_pointer;
	reg  [31:0]          second_pointer;
	reg  [31:0]          cur_desc;
	reg  [31:0]          buf_base;
	reg  [`SIZE_W-1:0]   buf_size;
	reg  [`SIZE_W-1:0]   byte_idx;
	reg                  in_second;
	reg                  sof_pending;
	reg                  last_sent;
	reg                  enable;
	reg  [31:0]          list_base;
	reg  [31:0]          frame_cnt;
	wire                 ring_end;
	wire                 chained;
	wire [`SIZE_W-1:0]   first_size;
	wire [`SIZE_W-1:0]   second_size;
	wire [31:0]          next_desc;
	wire                 fifo_valid;
	wire [8:0]           fifo_data;
	wire                 fifo_pop;
	wire [31:0]          byte_addr;
	wire                 write_done;

	// ----------------------------------------
	// descriptor decode and data buffer
	// ----------------------------------------
	rx_desc_decode u_decode (
		.i_control_word   (control_word),
		.i_second_pointer (second_pointer),
		.o_ring_end       (ring_end),
		.o_chained        (chained),
		.o_first_size     (first_size),
		.o_second_size    (second_size),
		.o_next_desc      (next_desc)
	);

	rx_byte_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.i_sys_clk   (i_sys_clk),
		.i_nrst      (i_nrst),
		.i_in_valid  (i_rx_valid),
		.i_in_data   ({i_rx_last, i_rx_data}),
		.o_in_ready  (o_rx_ready),
		.o_out_valid (fifo_valid),
		.o_out_data  (fifo_data),
		.i_out_ready (fifo_pop)
	);

	// byte leaves the buffer only once memory took it
	assign write_done = (state == ST_FILL) && o_mem_req && o_mem_we && i_mem_ack;
	assign fifo_pop   = write_done;
	// byte address from aligned base plus running index
	assign byte_addr  = buf_base + {{(32-`SIZE_W){1'b0}}, byte_idx};

	// ----------------------------------------
	// descriptor walk and buffer fill
	// ----------------------------------------
	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state          <= ST_IDLE;
			fetch_idx      <= 2'd0;
			control_word   <= 32'h0000_0000;
			first_pointer  <= 32'h0000_0000;
			second_pointer <= 32'h0000_0000;
			cur_desc       <= 32'h0000_0000;
			buf_base       <= 32'h0000_0000;
			buf_size       <= {`SIZE_W{1'b0}};
			byte_idx       <= {`SIZE_W{1'b0}};
			in_second      <= 1'b0;
			sof_pending    <= 1'b1;
			last_sent      <= 1'b0;
			frame_cnt      <= 32'h0000_0000;
			o_mem_req      <= 1'b0;
			o_mem_we       <= 1'b0;
			o_mem_addr     <= 32'h0000_0000;
			o_mem_wdata    <= 32'h0000_0000;
			o_mem_strb     <= 4'h0;
		end else begin
			case (state)
			ST_IDLE: begin
				if (enable) begin
					cur_desc  <= list_base;
					fetch_idx <= 2'd0;
					state     <= ST_FETCH;
				end
			end
			// read control, first and second pointer words
			ST_FETCH: begin
				if (o_mem_req && i_mem_ack) begin
					o_mem_req <= 1'b0;
					case (fetch_idx)
					2'd0: control_word <= i_mem_rdata;
					2'd1: first_pointer <= i_mem_rdata;
					default: second_pointer <= i_mem_rdata;
					endcase
					fetch_idx <= fetch_idx + 2'd1;
					if (fetch_idx == 2'd2)
						state <= ST_PICK1;
				end else if (!o_mem_req) begin
					o_mem_req  <= 1'b1;
					o_mem_we   <= 1'b0;
					o_mem_strb <= 4'h0;
					case (fetch_idx)
					2'd0: o_mem_addr <= cur_desc + `DESC_CTRL_OFS;
					2'd1: o_mem_addr <= cur_desc + `DESC_PTR1_OFS;
					default: o_mem_addr <= cur_desc + `DESC_PTR2_OFS;
					endcase
				end
			end
			// first buffer always comes first
			ST_PICK1: begin
				in_second <= 1'b0;
				buf_base  <= word_align(first_pointer);
				buf_size  <= first_size;
				if (first_size == {`SIZE_W{1'b0}})
					state <= ST_PICK2;
				else begin
					// frame start keeps true offset, else low bits dropped
					byte_idx <= sof_pending ?
						{{(`SIZE_W-2){1'b0}}, first_pointer[1:0]} :
						{`SIZE_W{1'b0}};
					state <= ST_FILL;
				end
			end
			// second buffer only when not chained
			ST_PICK2: begin
				in_second <= 1'b1;
				buf_base  <= word_align(second_pointer);
				buf_size  <= second_size;
				if (chained || second_size == {`SIZE_W{1'b0}})
					state <= ST_ADVANCE;
				else begin
					byte_idx <= sof_pending ?
						{{(`SIZE_W-2){1'b0}}, second_pointer[1:0]} :
						{`SIZE_W{1'b0}};
					state <= ST_FILL;
				end
			end
			// one byte per aligned word write, lane from offset
			ST_FILL: begin
				if (write_done) begin
					o_mem_req   <= 1'b0;
					byte_idx    <= byte_idx + 1'b1;
					sof_pending <= last_sent;
					if (last_sent) begin
						frame_cnt <= frame_cnt + 32'h0000_0001;
						state     <= ST_ADVANCE;
					end else if (byte_idx + 1'b1 >= buf_size)
						state <= in_second ? ST_ADVANCE : ST_PICK2;
				end else if (!o_mem_req && fifo_valid) begin
					o_mem_req   <= 1'b1;
					o_mem_we    <= 1'b1;
					o_mem_addr  <= word_align(byte_addr);
					o_mem_wdata <= {4{fifo_data[7:0]}};
					o_mem_strb  <= lane_strb(byte_addr[1:0]);
					last_sent   <= fifo_data[8];
				end
			end
			// ring end beats chain, chain beats stride
			ST_ADVANCE: begin
				if (ring_end)
					cur_desc <= list_base;
				else if (chained)
					cur_desc <= next_desc;
				else
					cur_desc <= cur_desc + `DESC_STRIDE;
				fetch_idx <= 2'd0;
				state     <= enable ? ST_FETCH : ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	reg              aw_held;
	reg              w_held;
	reg [ADDR_W-1:0] aw_addr;
	reg [31:0]       w_data;
	reg [3:0]        w_strb;

	// each channel accepted once, response waits for both
	assign o_s_awready = !aw_held && !o_s_bvalid;
	assign o_s_wready  = !w_held && !o_s_bvalid;
	assign o_s_arready = !o_s_rvalid;

	// byte-lane merge of a write
	function [31:0] merge_strb;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  strb;
		integer      i;
		begin
			merge_strb = old_val;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge_strb[i*8 +: 8] = new_val[i*8 +: 8];
		end
	endfunction

	// write channels, control and list base registers
	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			aw_held    <= 1'b0;
			w_held     <= 1'b0;
			aw_addr    <= {ADDR_W{1'b0}};
			w_data     <= 32'h0000_0000;
			w_strb     <= 4'h0;
			o_s_bvalid <= 1'b0;
			o_s_bresp  <= `RESP_OKAY;
			enable     <= CTRL_RST[`CTRL_ENABLE_BIT];
			list_base  <= `BASE_RESET_VAL;
		end else begin
			if (i_s_awvalid && o_s_awready) begin
				aw_held <= 1'b1;
				aw_addr <= i_s_awaddr;
			end
			if (i_s_wvalid && o_s_wready) begin
				w_held <= 1'b1;
				w_data <= i_s_wdata;
				w_strb <= i_s_wstrb;
			end
			if (aw_held && w_held && !o_s_bvalid) begin
				aw_held    <= 1'b0;
				w_held     <= 1'b0;
				o_s_bvalid <= 1'b1;
				o_s_bresp  <= `RESP_OKAY;
				case (aw_addr)
				`REG_CTRL: begin
					if (w_strb[0])
						enable <= w_data[`CTRL_ENABLE_BIT];
				end
				`REG_LIST_BASE: begin
					list_base <= merge_strb(list_base, w_data, w_strb);
				end
				`REG_CUR_DESC, `REG_STATUS, `REG_FRAME_CNT: begin
					o_s_bresp <= `RESP_OKAY; // read-only, write ignored
				end
				default: begin
					o_s_bresp <= `RESP_SLVERR;
				end
				endcase
			end else if (o_s_bvalid && i_s_bready)
				o_s_bvalid <= 1'b0;
		end
	end

	// read channel, data registered one cycle after address
	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_s_rvalid <= 1'b0;
			o_s_rdata  <= 32'h0000_0000;
			o_s_rresp  <= `RESP_OKAY;
		end else begin
			if (i_s_arvalid && o_s_arready) begin
				o_s_rvalid <= 1'b1;
				o_s_rresp  <= `RESP_OKAY;
				case (i_s_araddr)
				`REG_CTRL:      o_s_rdata <= {31'h0, enable};
				`REG_LIST_BASE: o_s_rdata <= list_base;
				`REG_CUR_DESC:  o_s_rdata <= cur_desc;
				`REG_STATUS:    o_s_rdata <= {26'h0, sof_pending, in_second,
					state == ST_IDLE, state};
				`REG_FRAME_CNT: o_s_rdata <= frame_cnt;
				default: begin
					o_s_rdata <= 32'h0000_0000;
					o_s_rresp <= `RESP_SLVERR;
				end
				endcase
			end else if (o_s_rvalid && i_s_rready)
				o_s_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== bench/rx_walk_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module rx_walk_monitor (
	input wire logic        i_sys_clk,
	input wire logic        i_nrst,
	input wire logic        o_s_awready,
	input wire logic        o_s_wready,
	input wire logic [1:0]  o_s_bresp,
	input wire logic        o_s_bvalid,
	input wire logic        i_s_bready,
	input wire logic        i_s_arvalid,
	input wire logic        o_s_arready,
	input wire logic        o_s_rvalid,
	input wire logic        o_mem_req,
	input wire logic        o_mem_we,
	input wire logic [31:0] o_mem_addr,
	input wire logic [31:0] o_mem_wdata,
	input wire logic [3:0]  o_mem_strb,
	input wire logic        i_mem_ack
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	// memory port: request held, dropped after ack, aligned words only
	req_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr)
		&& $stable(o_mem_strb) && $stable(o_mem_we)) else $error("memory request moved");
	req_drop_a: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
		else $error("memory request not dropped");
	wr_align_a: assert property (o_mem_req && o_mem_we |-> o_mem_addr[1:0] == 2'b00)
		else $error("write address not aligned");
	rd_place_a: assert property (o_mem_req && !o_mem_we |-> o_mem_addr[1:0] == 2'b00
		&& o_mem_addr[3:2] != 2'b00 && o_mem_strb == 4'h0) else $error("bad descriptor read");
	lane_copy_a: assert property (o_mem_req && o_mem_we |-> $onehot(o_mem_strb)
		&& o_mem_wdata == {4{o_mem_wdata[7:0]}}) else $error("bad write lanes");
	word_order_a: assert property (o_mem_req && !o_mem_we && i_mem_ack && o_mem_addr[3:2] == 2'd1
		|-> ##[2:16] (o_mem_req && !o_mem_we && o_mem_addr[3:2] == 2'd2))
		else $error("first pointer not read after control word");
	// register port handshakes
	resp_hold_a: assert property (o_s_bvalid && !i_s_bready |=> o_s_bvalid && $stable(o_s_bresp))
		else $error("write response dropped early");
	read_ans_a: assert property (i_s_arvalid && o_s_arready |=> o_s_rvalid)
		else $error("read answer late");
	wr_block_a: assert property (o_s_bvalid |-> !o_s_awready && !o_s_wready)
		else $error("write taken while response pending");
	resp_after_both_a: assert property ($rose(o_s_bvalid) |-> $past(o_s_awready) == 1'b0
		&& $past(o_s_wready) == 1'b0) else $error("write response before both channels");
endmodule
bind rx_desc_walker rx_walk_monitor rx_walk_monitor_inst (.i_sys_clk, .i_nrst, .o_s_awready,
	.o_s_wready, .o_s_bresp, .o_s_bvalid, .i_s_bready, .i_s_arvalid, .o_s_arready, .o_s_rvalid,
	.o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata, .o_mem_strb, .i_mem_ack);
`default_nettype wire

// ==== bench/mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module mem_model (
	input wire logic         i_sys_clk,
	input wire logic         i_nrst,
	input wire logic         i_req,
	input wire logic [31:0]  i_addr,
	input wire logic         i_slow,
	output logic             o_ack,
	output logic [31:0]      o_rdata
);
	logic [31:0] ram [0:63];
	logic [31:0] last;
	int          wait_n;
	// acks each request after a prompt or a slow random delay
	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_ack <= 1'b0;
			last <= 32'h0;
			wait_n <= 0;
		end else if (o_ack || !i_req) begin
			o_ack <= 1'b0;
			wait_n <= i_slow ? $urandom_range(9, 3) : $urandom_range(1, 0);
		end else if (wait_n > 0) begin
			wait_n <= wait_n - 1;
		end else begin
			o_ack <= 1'b1;
			last <= ram[i_addr[7:2]];
		end
	end
	// read data is valid only in the ack cycle, inverted otherwise
	assign o_rdata = o_ack ? last : ~last;
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rx_walk_consts.vh"
module tb_top;
	logic        i_sys_clk = 0, i_nrst = 0, slow = 0;
	logic [7:0]  i_s_awaddr = 0, i_s_araddr = 0, i_rx_data = 0;
	logic [31:0] i_s_wdata = 0, rd;
	logic [3:0]  i_s_wstrb = 4'hf;
	logic        i_s_awvalid = 0, i_s_wvalid = 0, i_s_bready = 0, i_s_arvalid = 0;
	logic        i_s_rready = 0, i_rx_valid = 0, i_rx_last = 0;
	logic [1:0]  rsp;
	logic [68:0] exp_q [$];
	logic [7:0]  fr [0:20];
	int          n_errors = 0, tests_run = 0, cyc = 0;
	wire         o_s_awready, o_s_wready, o_s_bvalid, o_s_arready, o_s_rvalid, o_rx_ready;
	wire         o_mem_req, o_mem_we, i_mem_ack;
	wire [1:0]   o_s_bresp, o_s_rresp;
	wire [31:0]  o_s_rdata, o_mem_addr, o_mem_wdata, i_mem_rdata;
	wire [3:0]   o_mem_strb;
	rx_desc_walker rx_desc_walker_inst (.i_sys_clk, .i_nrst, .i_s_awaddr, .i_s_awvalid,
		.o_s_awready, .i_s_wdata, .i_s_wstrb, .i_s_wvalid, .o_s_wready, .o_s_bresp, .o_s_bvalid,
		.i_s_bready, .i_s_araddr, .i_s_arvalid, .o_s_arready, .o_s_rdata, .o_s_rresp, .o_s_rvalid,
		.i_s_rready, .i_rx_valid, .i_rx_data, .i_rx_last, .o_rx_ready, .o_mem_req, .o_mem_we,
		.o_mem_addr, .o_mem_wdata, .o_mem_strb, .i_mem_ack, .i_mem_rdata);
	mem_model mem_model_inst (.i_sys_clk, .i_nrst, .i_req(o_mem_req), .i_addr(o_mem_addr),
		.i_slow(slow), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
	// clock and random memory pace
	always #25 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) slow <= 1'($urandom_range(1, 0));
	task automatic check(input logic [68:0] s, input logic [68:0] e, input string what);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic close_out;
		if (n_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge i_sys_clk);
		i_s_awaddr <= a;
		i_s_wdata <= d;
		i_s_awvalid <= 1;
		i_s_wvalid <= 1;
		fork
			begin do @(posedge i_sys_clk); while (!o_s_awready); i_s_awvalid <= 0; end
			begin do @(posedge i_sys_clk); while (!o_s_wready); i_s_wvalid <= 0; end
		join
		i_s_bready <= 1;
		do @(posedge i_sys_clk); while (o_s_bvalid !== 1'b1);
		r = o_s_bresp;
		i_s_bready <= 0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge i_sys_clk);
		i_s_araddr <= a;
		i_s_arvalid <= 1;
		i_s_rready <= 1;
		do @(posedge i_sys_clk); while (!o_s_arready);
		i_s_arvalid <= 0;
		do @(posedge i_sys_clk); while (o_s_rvalid !== 1'b1);
		rd = o_s_rdata;
		i_s_rready <= 0;
		check(69'({rd, o_s_rresp}), 69'({d, r}), "register read");
	endtask
	// notes one expected memory request
	task automatic ex(input logic we, input logic [31:0] a, input logic [1:0] ln, input logic [7:0] b);
		exp_q.push_back({we, a, we ? 4'h1 << ln : 4'h0, we ? {4{b}} : 32'h0});
	endtask
	task automatic fetch(input logic [31:0] d);
		ex(0, d + `DESC_CTRL_OFS, 0, 0);
		ex(0, d + `DESC_PTR1_OFS, 0, 0);
		ex(0, d + `DESC_PTR2_OFS, 0, 0);
	endtask
	task automatic place(input logic [31:0] p, input int i0, input int n, input int k);
		for (int j = 0; j < n; j++)
			ex(1, (p & ~32'h3) + 32'((i0 + j) & ~3), 2'(i0 + j), fr[k + j]);
	endtask
	task automatic send(input logic [7:0] b, input logic l);
		i_rx_valid <= 1;
		i_rx_data <= b;
		i_rx_last <= l;
		do @(posedge i_sys_clk); while (o_rx_ready !== 1'b1);
	endtask
	// compares each accepted memory request with the oldest note, and cuts a hang short
	always @(posedge i_sys_clk) begin
		if ((o_mem_req & i_mem_ack) === 1'b1) begin
			if (exp_q.size() == 0)
				check(69'(1), 69'(0), "extra memory request");
			else
				check({o_mem_we, o_mem_addr, o_mem_strb, o_mem_we ? o_mem_wdata : 32'h0},
					exp_q.pop_front(), "memory request");
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			close_out();
		end
	end
	initial begin
		rd = $urandom(32'h30b5);
		for (int k = 0; k < 21; k++)
			fr[k] = 8'($urandom);
		// three-descriptor ring; sizes kept multiples of four
		mem_model_inst.ram[17] = 32'h0004_0008;
		mem_model_inst.ram[18] = 32'hc000_0103;
		mem_model_inst.ram[19] = 32'h4000_0201;
		mem_model_inst.ram[21] = 32'h0008_4000;
		mem_model_inst.ram[23] = 32'h0000_0063;
		mem_model_inst.ram[25] = 32'h0008_c010;
		mem_model_inst.ram[26] = 32'h8000_0302;
		mem_model_inst.ram[27] = 32'h0000_0070;
		fetch(32'h40);
		place(32'hc000_0103, 3, 5, 0);
		place(32'h4000_0201, 0, 4, 5);
		fetch(32'h50);
		fetch(32'h60);
		place(32'h8000_0302, 0, 10, 9);
		fetch(32'h40);
		place(32'hc000_0103, 3, 2, 19);
		fetch(32'h50);
		fetch(32'h60);
		repeat (5) @(posedge i_sys_clk);
		i_nrst <= 1;
		rchk(`REG_CTRL, `CTRL_RESET_VAL, `RESP_OKAY);
		rchk(`REG_LIST_BASE, `BASE_RESET_VAL, `RESP_OKAY);
		rchk(8'h14, 32'h0, `RESP_SLVERR);
		axw(8'h14, 32'h1, rsp);
		check(69'(rsp), 69'(`RESP_SLVERR), "write response");
		axw(`REG_LIST_BASE, 32'h40, rsp);
		rchk(`REG_LIST_BASE, 32'h40, `RESP_OKAY);
		// two frames queued before the walk starts, so the fifo fills and refuses
		fork
			begin
				for (int k = 0; k < 21; k++)
					send(fr[k], k == 18 || k == 20);
				i_rx_valid <= 0;
			end
		join_none
		repeat (40) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		check(69'(o_rx_ready), 69'(0), "rx ready while full");
		axw(`REG_CTRL, 32'h1, rsp);
		for (int t = 0; t < 5000 && exp_q.size() > 0; t++)
			@(posedge i_sys_clk);
		check(69'(exp_q.size()), 69'(0), "pending requests");
		rchk(`REG_CUR_DESC, 32'h60, `RESP_OKAY);
		rchk(`REG_FRAME_CNT, 32'h2, `RESP_OKAY);
		// waiting in fill of a fresh frame, first buffer
		rchk(`REG_STATUS, 32'h0000_0024, `RESP_OKAY);
		close_out();
	end
endmodule
`default_nettype wire
